// [core/fault_alert_monitor.sv]
/*
  Fault and alert monitor: compares measurement samples with fixed limits,
  drives the power and error indicators and keeps alert states.
  Assumes samples are valid whenever update is high, scaled as the package
  states, and that commands are single-cycle pulses.
*/
`timescale 1ns/1ps
module fault_alert_monitor #(
	parameter int BLINK_HALF = fault_alert_pkg::BLINK_HALF_CYC
) (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic                     update,
	input  wire logic                     rail24_present,
	input  wire logic signed [15:0]       usb_mv,
	input  wire logic signed [15:0]       rail24_mv,
	input  wire logic signed [15:0]       cell_temp,
	input  wire logic signed [15:0]       cell_temp2,
	input  wire logic signed [15:0]       block_temp,
	input  wire logic [5:0]               rail_limit,
	input  wire logic                     flash_error,
	input  wire logic                     firmware_error,
	input  wire logic                     self_test_fail,
	input  wire logic [1:0]               input_current_mode,
	input  wire logic signed [31:0]       input_level,
	input  wire logic signed [31:0]       loop_current,
	input  wire logic [2:0]               out_cannot_source,
	input  wire logic [2:0]               out_over_temp,
	input  wire logic                     heater_on,
	input  wire logic                     servo_at_limit,
	input  wire logic                     safe_mode,
	input  wire logic [2:0]               command,
	input  wire logic [4:0]               alert_select,
	output logic [15:0]                   faults,
	output logic [24:0]                   alerts,
	output logic [49:0]                   alert_state,
	output logic                          fault_summary,
	output logic                          alert_summary,
	output logic                          power_led,
	output logic                          error_led,
	output logic [1:0]                    loop_power_enable
);
	localparam int NF = fault_alert_pkg::NUM_FAULTS;
	localparam int NA = fault_alert_pkg::NUM_ALERTS;
	localparam int NE = fault_alert_pkg::NUM_EXT_FAULTS;

	function automatic logic above(input logic signed [15:0] v,
		input logic signed [15:0] lim);
		above = v > lim;
	endfunction : above

	function automatic logic below(input logic signed [15:0] v,
		input logic signed [15:0] lim);
		below = v < lim;
	endfunction : below

	function automatic logic signed [15:0] absdiff(
		input logic signed [15:0] a, input logic signed [15:0] b);
		logic signed [16:0] d;
		d = 17'(a) - 17'(b);
		if (d < 0)
			d = -d;
		absdiff = (d > 17'sh07FFF) ? 16'sh7FFF : d[15:0];
	endfunction : absdiff

	alert_cmd_if cbus ();

	alert_keeper keeper (
		.clk   (clk),
		.reset (reset),
		.bus   (cbus.keeper)
	);

	// Threshold decode from the current samples.
	logic               on_usb;
	logic signed [15:0] tdiff;
	logic [NF-1:0]      next_faults;
	logic [NA-1:0]      next_alerts;
	logic signed [15:0] in_lvl [2];
	logic signed [15:0] loop_i [2];

	assign on_usb = ~rail24_present;
	assign tdiff = absdiff(cell_temp, cell_temp2);
	assign in_lvl[0] = input_level[15:0];
	assign in_lvl[1] = input_level[31:16];
	assign loop_i[0] = loop_current[15:0];
	assign loop_i[1] = loop_current[31:16];

	always_comb begin
		next_faults = '0;
		next_faults[fault_alert_pkg::F_USB_UV] = on_usb &&
			below(usb_mv, fault_alert_pkg::USB_FAULT_LO);
		next_faults[fault_alert_pkg::F_USB_OV] = on_usb &&
			above(usb_mv, fault_alert_pkg::USB_FAULT_HI);
		next_faults[fault_alert_pkg::F_24_OV] = !on_usb &&
			above(rail24_mv, fault_alert_pkg::RAIL24_FAULT_HI);
		next_faults[fault_alert_pkg::F_CELL_UT] =
			below(cell_temp, fault_alert_pkg::CELL_FAULT_LO);
		next_faults[fault_alert_pkg::F_CELL_OT] =
			above(cell_temp, fault_alert_pkg::CELL_FAULT_HI);
		next_faults[fault_alert_pkg::F_HEATER] =
			above(block_temp, fault_alert_pkg::BLOCK_FAULT_HI);
		next_faults[fault_alert_pkg::F_MISMATCH] =
			above(tdiff, fault_alert_pkg::MISMATCH_FAULT);
		next_faults[fault_alert_pkg::F_FLASH] = flash_error;
		next_faults[fault_alert_pkg::F_FIRMWARE] = firmware_error;
		next_faults[fault_alert_pkg::F_R14_UV +: 6] = rail_limit;
		next_faults[fault_alert_pkg::F_SELFTEST] = self_test_fail;
	end

	always_comb begin
		next_alerts = '0;
		for (int i = 0; i < 2; i++) begin
			next_alerts[fault_alert_pkg::A_IN_UV + i] = !input_current_mode[i]
				&& below(in_lvl[i], fault_alert_pkg::VIN_LO);
			next_alerts[fault_alert_pkg::A_IN_OV + i] = !input_current_mode[i]
				&& above(in_lvl[i], fault_alert_pkg::VIN_HI);
			next_alerts[fault_alert_pkg::A_IN_UC + i] = input_current_mode[i]
				&& below(in_lvl[i], fault_alert_pkg::IIN_LO);
			next_alerts[fault_alert_pkg::A_IN_OC + i] = input_current_mode[i]
				&& above(in_lvl[i], fault_alert_pkg::IIN_HI);
			next_alerts[fault_alert_pkg::A_LOOP + i] =
				above(loop_i[i], fault_alert_pkg::LOOP_LIMIT);
		end
		next_alerts[fault_alert_pkg::A_OUT_CUR +: 3] = out_cannot_source;
		next_alerts[fault_alert_pkg::A_OUT_TEMP +: 3] = out_over_temp;
		next_alerts[fault_alert_pkg::A_CELL_UT] =
			below(cell_temp, fault_alert_pkg::CELL_ALERT_LO);
		next_alerts[fault_alert_pkg::A_CELL_OT] =
			above(cell_temp, fault_alert_pkg::CELL_ALERT_HI);
		next_alerts[fault_alert_pkg::A_MISMATCH] =
			above(tdiff, fault_alert_pkg::MISMATCH_ALERT);
		next_alerts[fault_alert_pkg::A_USB_UV] = on_usb &&
			below(usb_mv, fault_alert_pkg::USB_ALERT_LO);
		next_alerts[fault_alert_pkg::A_USB_OV] = on_usb &&
			above(usb_mv, fault_alert_pkg::USB_ALERT_HI);
		next_alerts[fault_alert_pkg::A_24_UV] = !on_usb &&
			below(rail24_mv, fault_alert_pkg::RAIL24_ALERT_LO);
		next_alerts[fault_alert_pkg::A_24_OV] = !on_usb &&
			above(rail24_mv, fault_alert_pkg::RAIL24_ALERT_HI);
		next_alerts[fault_alert_pkg::A_HEATER] =
			heater_on && servo_at_limit;
		next_alerts[fault_alert_pkg::A_SAFE] = safe_mode;
	end

	// Raw levels, sampled once per update strobe.
	logic [NF-1:0] fault_raw;
	logic [NA-1:0] alert_raw;

	always_ff @(posedge clk) begin
		if (reset) begin
			fault_raw <= '0;
			alert_raw <= '0;
		end else if (update) begin
			fault_raw <= next_faults;
			alert_raw <= next_alerts;
		end
	end

	assign cbus.raw = alert_raw;
	assign cbus.cmd = fault_alert_pkg::cmd_t'(command);
	assign cbus.sel = alert_select;

	// Blink divider for the power indicator.
	logic [31:0] blink_cnt;
	logic        blink;
	logic        ext_fault;
	logic        sys_fault;
	logic        blink_wrap;

	assign ext_fault = |fault_raw[NE-1:0];
	assign sys_fault = |fault_raw[NF-1:NE];
	assign blink_wrap = blink_cnt == 32'(BLINK_HALF - 1);

	always_ff @(posedge clk) begin
		if (reset || !ext_fault) begin
			blink_cnt <= '0;
			blink <= 1'b0;
		end else if (blink_wrap) begin
			blink_cnt <= '0;
			blink <= ~blink;
		end else begin
			blink_cnt <= blink_cnt + 32'h00000001;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			faults <= '0;
			alerts <= '0;
			alert_state <= '0;
			fault_summary <= 1'b0;
			alert_summary <= 1'b0;
			power_led <= 1'b0;
			error_led <= 1'b0;
			loop_power_enable <= 2'b11;
		end else begin
			faults <= fault_raw;
			alerts <= cbus.active;
			alert_state <= cbus.state;
			fault_summary <= |fault_raw;
			alert_summary <= cbus.summary;
			power_led <= ext_fault ? blink : 1'b1;
			error_led <= sys_fault;
			loop_power_enable <=
				~cbus.active[fault_alert_pkg::A_LOOP +: 2];
		end
	end

	property p_err_led;
		@(posedge clk) disable iff (reset)
		sys_fault |=> error_led;
	endproperty
	a_err_led: assert property (p_err_led) else $error("error led off");

	property p_loop_cut;
		@(posedge clk) disable iff (reset)
		cbus.active[fault_alert_pkg::A_LOOP] |=> !loop_power_enable[0];
	endproperty
	a_loop_cut: assert property (p_loop_cut) else $error("loop not cut");

	property p_hold;
		@(posedge clk) disable iff (reset)
		!update |=> $stable(fault_raw);
	endproperty
	a_hold: assert property (p_hold) else $error("eval off strobe");

	sequence s_mute;
		cbus.cmd == fault_alert_pkg::CMD_MUTE_ONCE &&
			cbus.active[alert_select];
	endsequence
	property p_mute;
		@(posedge clk) disable iff (reset)
		s_mute |=> cbus.state[2*$past(alert_select) +: 2] !=
			fault_alert_pkg::ST_NORMAL;
	endproperty
	a_mute: assert property (p_mute)
		else $error("mute once lost");

	sequence s_mute_always;
		cbus.cmd == fault_alert_pkg::CMD_MUTE_ALWAYS &&
			alert_select < 5'(NA);
	endsequence
	property p_mute_always;
		@(posedge clk) disable iff (reset)
		s_mute_always |=> cbus.state[2*$past(alert_select) +: 2] ==
			fault_alert_pkg::ST_MUTED_ALWAYS;
	endproperty
	a_mute_always: assert property (p_mute_always)
		else $error("mute always lost");

	sequence s_loop_kept;
		cbus.active[fault_alert_pkg::A_LOOP] &&
			!(cbus.cmd == fault_alert_pkg::CMD_DISMISS &&
			alert_select == 5'(fault_alert_pkg::A_LOOP));
	endsequence
	property p_loop_latch;
		@(posedge clk) disable iff (reset)
		s_loop_kept |=> cbus.active[fault_alert_pkg::A_LOOP];
	endproperty
	a_loop_latch: assert property (p_loop_latch)
		else $error("loop alert dropped");

	property p_dismiss;
		@(posedge clk) disable iff (reset)
		cbus.cmd == fault_alert_pkg::CMD_DISMISS &&
			alert_select == 5'(fault_alert_pkg::A_LOOP) &&
			!alert_raw[fault_alert_pkg::A_LOOP]
			|=> !cbus.active[fault_alert_pkg::A_LOOP];
	endproperty
	a_dismiss: assert property (p_dismiss)
		else $error("dismiss ignored");

	property p_unmute;
		@(posedge clk) disable iff (reset)
		cbus.cmd == fault_alert_pkg::CMD_UNMUTE_ALL |=> cbus.state == '0;
	endproperty
	a_unmute: assert property (p_unmute)
		else $error("mute kept after unmute");

	sequence s_sample;
		update ##1 1'b1;
	endsequence
	property p_fault_follow;
		@(posedge clk) disable iff (reset)
		s_sample |=> faults == $past(next_faults, 2);
	endproperty
	a_fault_follow: assert property (p_fault_follow)
		else $error("fault vector stale");

	property p_usb_only;
		@(posedge clk) disable iff (reset)
		update && rail24_present |=>
			!fault_raw[fault_alert_pkg::F_USB_UV] &&
			!fault_raw[fault_alert_pkg::F_USB_OV] &&
			!alert_raw[fault_alert_pkg::A_USB_UV] &&
			!alert_raw[fault_alert_pkg::A_USB_OV];
	endproperty
	a_usb_only: assert property (p_usb_only)
		else $error("usb rail watched on 24 V");

	property p_power_steady;
		@(posedge clk) disable iff (reset)
		!ext_fault |=> power_led;
	endproperty
	a_power_steady: assert property (p_power_steady)
		else $error("power led off");

	property p_err_off;
		@(posedge clk) disable iff (reset)
		!sys_fault |=> !error_led;
	endproperty
	a_err_off: assert property (p_err_off)
		else $error("error led lit");

	property p_summary;
		@(posedge clk) disable iff (reset)
		!(|cbus.active) |=> !alert_summary;
	endproperty
	a_summary: assert property (p_summary)
		else $error("alert summary without alert");

	property p_loop_restore;
		@(posedge clk) disable iff (reset)
		!cbus.active[fault_alert_pkg::A_LOOP + 1] |=> loop_power_enable[1];
	endproperty
	a_loop_restore: assert property (p_loop_restore)
		else $error("loop power not restored");

endmodule : fault_alert_monitor

// [core/fault_alert_pkg.sv]
/*
  Constants for the fault and alert monitor: thresholds, fault and alert
  indices, alert state codes, command codes and the indicator blink timing.
  Assumes measurements arrive as signed integers in millivolts, microamps
  and hundredths of a degree Celsius.
*/
package fault_alert_pkg;

	// Measurement scaling: supplies in mV, currents in uA, temps in 0.01 C.
	localparam int MEAS_W = 16;

	localparam logic signed [15:0] USB_FAULT_LO    = 16'sh1162; // 4450 mV
	localparam logic signed [15:0] USB_FAULT_HI    = 16'sh157C; // 5500 mV
	localparam logic signed [15:0] RAIL24_FAULT_HI = 16'sh6D60; // 28000 mV
	localparam logic signed [15:0] USB_ALERT_LO    = 16'sh11F8; // 4600 mV
	localparam logic signed [15:0] USB_ALERT_HI    = 16'sh14B4; // 5300 mV
	localparam logic signed [15:0] RAIL24_ALERT_LO = 16'sh55F0; // 22000 mV
	localparam logic signed [15:0] RAIL24_ALERT_HI = 16'sh6590; // 26000 mV
	localparam logic signed [15:0] CELL_FAULT_LO   = -16'sh07D0; // -20 C
	localparam logic signed [15:0] CELL_FAULT_HI   = 16'sh1F40; // 80 C
	localparam logic signed [15:0] BLOCK_FAULT_HI  = 16'sh2328; // 90 C
	localparam logic signed [15:0] MISMATCH_FAULT  = 16'sh01F4; // 5 C
	localparam logic signed [15:0] CELL_ALERT_LO   = 16'sh0000; // 0 C
	localparam logic signed [15:0] CELL_ALERT_HI   = 16'sh1B58; // 70 C
	localparam logic signed [15:0] MISMATCH_ALERT  = 16'sh00C8; // 2 C
	localparam logic signed [15:0] VIN_LO          = -16'sh0064; // -100 mV
	localparam logic signed [15:0] VIN_HI          = 16'sh27D8; // 10200 mV
	localparam logic signed [15:0] IIN_LO          = 16'sh0DAC; // 3500 uA
	localparam logic signed [15:0] IIN_HI          = 16'sh6590; // 26000 uA
	localparam logic signed [15:0] LOOP_HI         = 16'sh7FFF; // 32767 counts, full-scale cap
	// Loop current is given in 2 uA steps so 50 mA fits: 25000 counts.
	localparam logic signed [15:0] LOOP_LIMIT      = 16'sh61A8;

	// Fault vector bit positions.
	localparam int F_USB_UV   = 0;
	localparam int F_USB_OV   = 1;
	localparam int F_24_OV    = 2;
	localparam int F_CELL_UT  = 3;
	localparam int F_CELL_OT  = 4;
	localparam int F_FLASH    = 5;
	localparam int F_FIRMWARE = 6;
	localparam int F_HEATER   = 7;
	localparam int F_R14_UV   = 8;
	localparam int F_R14_OV   = 9;
	localparam int F_R33_UV   = 10;
	localparam int F_R33_OV   = 11;
	localparam int F_R5I_UV   = 12;
	localparam int F_R5I_OV   = 13;
	localparam int F_MISMATCH = 14;
	localparam int F_SELFTEST = 15;
	localparam int NUM_FAULTS = 16;
	localparam int NUM_EXT_FAULTS = 3;

	// Alert vector bit positions; input alerts are per input (2 inputs).
	localparam int A_IN_UV    = 0;  // 0..1
	localparam int A_IN_OV    = 2;  // 2..3
	localparam int A_IN_UC    = 4;  // 4..5
	localparam int A_IN_OC    = 6;  // 6..7
	localparam int A_LOOP     = 8;  // 8..9
	localparam int A_OUT_CUR  = 10; // 10..12, measure out then 1, 2
	localparam int A_OUT_TEMP = 13; // 13..15
	localparam int A_CELL_UT  = 16;
	localparam int A_CELL_OT  = 17;
	localparam int A_MISMATCH = 18;
	localparam int A_USB_UV   = 19;
	localparam int A_USB_OV   = 20;
	localparam int A_24_UV    = 21;
	localparam int A_24_OV    = 22;
	localparam int A_HEATER   = 23;
	localparam int A_SAFE     = 24;
	localparam int NUM_ALERTS = 25;
	localparam int ALERT_IDX_W = 5;

	typedef enum logic [1:0] {
		ST_NORMAL = 2'b00,
		ST_MUTED_ONCE = 2'b01,
		ST_MUTED_ALWAYS = 2'b10
	} mute_t;

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_DISMISS = 3'b001,
		CMD_MUTE_ONCE = 3'b010,
		CMD_MUTE_ALWAYS = 3'b011,
		CMD_UNMUTE_ALL = 3'b100
	} cmd_t;

	// Blink at about 4 Hz: toggle every 125 ms.
	localparam int CLK_HZ = 10_000_000;
	localparam int BLINK_HALF_MS = 125;
	localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;

endpackage : fault_alert_pkg

// [core/alert_cmd_if.sv]
/*
  Interface carrying operator commands from the monitor to its alert state
  keeper, and the alert state back.  Assumes one command per cycle at most.
*/
`timescale 1ns/1ps
interface alert_cmd_if;
	fault_alert_pkg::cmd_t        cmd;
	logic [fault_alert_pkg::ALERT_IDX_W-1:0] sel;
	logic [fault_alert_pkg::NUM_ALERTS-1:0]  raw;
	logic [fault_alert_pkg::NUM_ALERTS-1:0]  active;
	logic [2*fault_alert_pkg::NUM_ALERTS-1:0] state;
	logic                         summary;

	modport monitor (output cmd, output sel, output raw,
		input active, input state, input summary);
	modport keeper (input cmd, input sel, input raw,
		output active, output state, output summary);
endinterface : alert_cmd_if

// [core/alert_keeper.sv]
/*
  Per-alert state keeper: latches the loop alerts, keeps mute settings and
  forms the unmuted alert summary.  Assumes raw alert levels are updated
  by the monitor once per evaluation.
*/
`timescale 1ns/1ps
module alert_keeper (
	input  wire logic  clk,
	input  wire logic  reset,
	alert_cmd_if.keeper bus
);
	localparam int N = fault_alert_pkg::NUM_ALERTS;

	logic [N-1:0] latch;
	logic [N-1:0] muted_once;
	logic [N-1:0] muted_always;
	logic [N-1:0] sel_hot;
	logic [N-1:0] sticky_mask;
	logic [N-1:0] act;
	logic [N-1:0] dismiss;

	assign sel_hot = N'(1) << bus.sel;
	assign sticky_mask = N'(2'b11) << fault_alert_pkg::A_LOOP;
	assign dismiss = (bus.cmd == fault_alert_pkg::CMD_DISMISS) ?
		sel_hot : '0;
	// Loop alerts hold until dismissed; the set wins over a dismiss.
	assign act = (bus.raw & ~sticky_mask) | (latch & sticky_mask);

	always_ff @(posedge clk) begin
		if (reset || bus.cmd == fault_alert_pkg::CMD_UNMUTE_ALL) begin
			muted_once <= '0;
			muted_always <= '0;
		end else begin
			// A once-muted alert returns to normal when it goes away.
			muted_once <= (muted_once & act) |
				((bus.cmd == fault_alert_pkg::CMD_MUTE_ONCE) ?
				sel_hot & act : '0);
			muted_always <= muted_always |
				((bus.cmd == fault_alert_pkg::CMD_MUTE_ALWAYS) ?
				sel_hot : '0);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			latch <= '0;
		end else begin
			latch <= ((latch & ~dismiss) | bus.raw) & sticky_mask;
		end
	end

	assign bus.active = act;
	assign bus.summary = |(act & ~muted_once & ~muted_always);
	always_comb begin
		for (int i = 0; i < N; i++) begin
			bus.state[2*i +: 2] = muted_always[i] ?
				fault_alert_pkg::ST_MUTED_ALWAYS :
				(muted_once[i] ? fault_alert_pkg::ST_MUTED_ONCE :
				fault_alert_pkg::ST_NORMAL);
		end
	end

endmodule : alert_keeper

// [dv/meas_source_model.sv]
/*
  Measurement source model: issues the sample strobe that marks the
  measurement levels as valid, once every PERIOD clocks.
  Assumes the bench holds the measurement levels steady between strobes.
*/
`timescale 1ns/1ps
module meas_source_model #(
	parameter int PERIOD = 5
) (
	input  wire logic clk,
	input  wire logic reset,
	output logic      update
);
	logic [7:0] count;
	logic [7:0] next_count;

	// The strobe stays low in reset so no sample is taken too early.
	assign next_count = (count == 8'(PERIOD - 1)) ? 8'h00 : count + 8'h01;

	always_ff @(posedge clk) begin
		if (reset) begin
			count  <= 8'h00;
			update <= 1'b0;
		end else begin
			count  <= next_count;
			update <= (count == 8'(PERIOD - 1));
		end
	end
endmodule : meas_source_model

// [dv/fault_alert_monitor_tb_top.sv]
/*
  Testbench for the fault and alert monitor: table of single-cause cases,
  then blink, latching, mute and reset cases.
  Assumes the package scaling and a shortened blink half period of 10.
*/
`timescale 1ns/1ps
module fault_alert_monitor_tb_top;
	typedef struct packed {
		logic [3:0]  k;
		logic [31:0] v;
		logic [15:0] ef;
		logic [24:0] ea;
	} row_t;
	localparam int PER = 5;
	logic               clk;
	logic               reset;
	logic               update;
	logic               rail24_present;
	logic signed [15:0] usb_mv;
	logic signed [15:0] rail24_mv;
	logic signed [15:0] cell_temp;
	logic signed [15:0] cell_temp2;
	logic signed [15:0] block_temp;
	logic [5:0]         rail_limit;
	logic               flash_error;
	logic               firmware_error;
	logic               self_test_fail;
	logic [1:0]         input_current_mode;
	logic signed [31:0] input_level;
	logic signed [31:0] loop_current;
	logic [2:0]         out_cannot_source;
	logic [2:0]         out_over_temp;
	logic               heater_on;
	logic               servo_at_limit;
	logic               safe_mode;
	logic [2:0]         command;
	logic [4:0]         alert_select;
	logic [15:0]        faults;
	logic [24:0]        alerts;
	logic [49:0]        alert_state;
	logic               fault_summary;
	logic               alert_summary;
	logic               power_led;
	logic               error_led;
	logic [1:0]         loop_power_enable;
	int                 error_cnt = 0;
	int                 tests_run = 0;
	int                 tog;
	int                 lit;
	row_t               rows[$] = '{
		'{4'h0, 32'h0, 16'h0, 25'h0},
		'{4'h1, 32'h1161, 16'h1, 25'h80000},
		'{4'h1, 32'h1162, 16'h0, 25'h80000},
		'{4'h1, 32'h11F8, 16'h0, 25'h0},
		'{4'h1, 32'h14B5, 16'h0, 25'h100000},
		'{4'h1, 32'h157D, 16'h2, 25'h100000},
		'{4'hF, 32'h1161, 16'h0, 25'h0},
		'{4'h2, 32'h6D61, 16'h4, 25'h400000},
		'{4'h2, 32'h6590, 16'h0, 25'h0},
		'{4'h2, 32'h55EF, 16'h0, 25'h200000},
		'{4'hE, 32'h7530, 16'h0, 25'h0},
		'{4'h3, 32'hF82F, 16'h8, 25'h10000},
		'{4'h3, 32'hFFFF, 16'h0, 25'h10000},
		'{4'h3, 32'h1F41, 16'h10, 25'h20000},
		'{4'h3, 32'h1B58, 16'h0, 25'h0},
		'{4'h5, 32'h2329, 16'h80, 25'h0},
		'{4'h5, 32'h2328, 16'h0, 25'h0},
		'{4'h4, 32'h1195, 16'h4000, 25'h40000},
		'{4'h4, 32'h0DAB, 16'h4000, 25'h40000},
		'{4'h4, 32'h1068, 16'h0, 25'h0},
		'{4'h6, 32'h1388FF9B, 16'h0, 25'h1},
		'{4'h6, 32'h27D91388, 16'h0, 25'h8},
		'{4'h7, 32'h13880DAB, 16'h0, 25'h10},
		'{4'h7, 32'h65911388, 16'h0, 25'h80},
		'{4'h7, 32'h13880DAC, 16'h0, 25'h0},
		'{4'h9, 32'h3F, 16'h3F00, 25'h0},
		'{4'hA, 32'h7, 16'h8060, 25'h0},
		'{4'hB, 32'h5, 16'h0, 25'h1400},
		'{4'hC, 32'h2, 16'h0, 25'h4000},
		'{4'hD, 32'h3, 16'h0, 25'h800000},
		'{4'hD, 32'h2, 16'h0, 25'h0},
		'{4'hD, 32'h1, 16'h0, 25'h0}};

	fault_alert_monitor #(.BLINK_HALF(10)) DUT (
		.clk(clk), .reset(reset), .update(update),
		.rail24_present(rail24_present), .usb_mv(usb_mv),
		.rail24_mv(rail24_mv), .cell_temp(cell_temp),
		.cell_temp2(cell_temp2), .block_temp(block_temp),
		.rail_limit(rail_limit), .flash_error(flash_error),
		.firmware_error(firmware_error), .self_test_fail(self_test_fail),
		.input_current_mode(input_current_mode),
		.input_level(input_level), .loop_current(loop_current),
		.out_cannot_source(out_cannot_source),
		.out_over_temp(out_over_temp), .heater_on(heater_on),
		.servo_at_limit(servo_at_limit), .safe_mode(safe_mode),
		.command(command), .alert_select(alert_select),
		.faults(faults), .alerts(alerts), .alert_state(alert_state),
		.fault_summary(fault_summary), .alert_summary(alert_summary),
		.power_led(power_led), .error_led(error_led),
		.loop_power_enable(loop_power_enable));

	meas_source_model #(.PERIOD(PER)) src (
		.clk(clk), .reset(reset), .update(update));

	initial clk = 1'b0;
	always #50 clk = ~clk;

	task automatic finish_test;
		$display("Checks %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	task automatic check(input string nm, input logic [49:0] seen,
		input logic [49:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// Sets one cause from field k to value v, all else nominal.
	task automatic set_in(input logic [3:0] k, input logic [31:0] v);
		rail24_present <= !(k == 4'h1 || k == 4'hE);
		usb_mv <= (k == 4'h1 || k == 4'hF) ? v[15:0] : 16'sh1388;
		rail24_mv <= (k == 4'h2 || k == 4'hE) ? v[15:0] : 16'sh5DC0;
		cell_temp <= (k == 4'h3) ? v[15:0] : 16'sh0FA0;
		cell_temp2 <= (k == 4'h3 || k == 4'h4) ? v[15:0] : 16'sh0FA0;
		block_temp <= (k == 4'h5) ? v[15:0] : 16'sh1388;
		input_current_mode <= (k == 4'h7) ? 2'h3 : {1'b0, k == 4'h8};
		input_level <= (k == 4'h6 || k == 4'h7) ? v : 32'h13881388;
		loop_current <= (k == 4'h8) ? v : 32'h0;
		rail_limit <= (k == 4'h9) ? v[5:0] : 6'h0;
		{self_test_fail, firmware_error, flash_error} <= (k == 4'hA) ? v[2:0] : 3'h0;
		out_cannot_source <= (k == 4'hB) ? v[2:0] : 3'h0;
		out_over_temp <= (k == 4'hC) ? v[2:0] : 3'h0;
		{safe_mode, servo_at_limit, heater_on} <= (k == 4'hD) ? v[2:0] : 3'h0;
	endtask : set_in

	task automatic apply(input logic [3:0] k, input logic [31:0] v);
		@(posedge clk);
		set_in(k, v);
	endtask : apply

	task automatic settle;
		repeat (2 * PER + 3) @(posedge clk);
		#1;
	endtask : settle

	task automatic cmd(input logic [2:0] c, input logic [4:0] s);
		@(posedge clk);
		command <= c;
		alert_select <= s;
		@(posedge clk);
		command <= 3'h0;
		repeat (2) @(posedge clk);
		#1;
	endtask : cmd

	// Counts power indicator changes and lit error indicator cycles.
	task automatic watch(output int t, output int l);
		logic p;
		t = 0;
		l = 0;
		p = power_led;
		repeat (40) begin
			@(posedge clk);
			#1;
			if (power_led !== p) t++;
			if (error_led === 1'b1) l++;
			p = power_led;
		end
	endtask : watch

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		finish_test;
	end

	initial begin
		reset = 1'b1;
		command = 3'h0;
		alert_select = 5'h00;
		set_in(4'h0, 32'h0);
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		settle;
		check("state_init", alert_state, 50'h0);
		check("loop_init", loop_power_enable, 50'h3);
		foreach (rows[i]) begin
			apply(rows[i].k, rows[i].v);
			settle;
			check("faults", faults, rows[i].ef);
			check("alerts", alerts, rows[i].ea);
			check("fault_summary", fault_summary, |rows[i].ef);
			check("error_led", error_led, |rows[i].ef[15:3]);
			check("alert_summary", alert_summary, |rows[i].ea);
			if (rows[i].ef[2:0] == 3'h0)
				check("power_led", power_led, 50'h1);
		end
		apply(4'h1, 32'h1161);
		settle;
		watch(tog, lit);
		check("blink_toggles", 50'(tog), 50'h4);
		check("error_off", 50'(lit), 50'h0);
		apply(4'hA, 32'h1);
		settle;
		watch(tog, lit);
		check("power_steady", 50'(tog), 50'h0);
		check("error_steady", 50'(lit), 50'd40);
		apply(4'h8, 32'h61A9);
		settle;
		check("loop_alert", alerts[8], 50'h1);
		check("loop_cut", loop_power_enable, 50'h2);
		apply(4'h0, 32'h0);
		settle;
		check("loop_held", alerts[8], 50'h1);
		check("loop_still_cut", loop_power_enable, 50'h2);
		cmd(3'h1, 5'h08);
		check("loop_cleared", alerts[8], 50'h0);
		check("loop_restored", loop_power_enable, 50'h3);
		apply(4'h8, 32'h61A9);
		settle;
		cmd(3'h1, 5'h08);
		settle;
		check("loop_reassert", alerts[8], 50'h1);
		apply(4'h0, 32'h0);
		settle;
		cmd(3'h1, 5'h08);
		apply(4'hD, 32'h4);
		settle;
		check("summary_on", alert_summary, 50'h1);
		cmd(3'h2, 5'h18);
		check("state_once", alert_state[49:48], 50'h1);
		check("summary_once", alert_summary, 50'h0);
		cmd(3'h2, 5'h17);
		check("state_idle", alert_state[47:46], 50'h0);
		apply(4'h0, 32'h0);
		settle;
		apply(4'hD, 32'h4);
		settle;
		check("state_back", alert_state[49:48], 50'h0);
		check("summary_back", alert_summary, 50'h1);
		cmd(3'h3, 5'h18);
		apply(4'h0, 32'h0);
		settle;
		apply(4'hD, 32'h4);
		settle;
		check("state_always", alert_state[49:48], 50'h2);
		check("summary_always", alert_summary, 50'h0);
		cmd(3'h4, 5'h00);
		check("state_unmuted", alert_state, 50'h0);
		check("summary_unmuted", alert_summary, 50'h1);
		cmd(3'h3, 5'h18);
		@(posedge clk);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		settle;
		check("state_reset", alert_state, 50'h0);
		check("summary_reset", alert_summary, 50'h1);
		finish_test;
	end
endmodule : fault_alert_monitor_tb_top
